// [include/oag_cfg.svh]
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH
// ****************************************
// Address bases and field limits
// ****************************************
`define OAG_SFR_BASE 16'hFE00
`define OAG_RAMBIT_BASE 16'hFD00
`define OAG_SFRBIT_BASE 16'hFF00
`define OAG_GPR_MIN 8'hF0
`define OAG_SFRBIT_MIN 8'h80
`define OAG_OFF_MSB 13
`define OAG_SEL_LSB 14
`define OAG_DELTA_W 16'h0002
`define OAG_DELTA_B 16'h0001
`define OAG_PAGE_W 4
`endif

// [include/oag_pkg.sv]
package oag_pkg;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    OAG_RW = 4'h0,
    OAG_RB = 4'h1,
    OAG_REG = 4'h2,
    OAG_BITOFF = 4'h3,
    OAG_BITADDR = 4'h4,
    OAG_MEM = 4'h5,
    OAG_IND = 4'h6,
    OAG_POSTINC = 4'h7,
    OAG_PREDEC = 4'h8,
    OAG_PLUSK = 4'h9
  } oag_mode_t;
  typedef enum logic [0:0] {
    OAG_IDLE = 1'b0,
    OAG_WAIT = 1'b1
  } oag_state_t;
  typedef struct packed {
    oag_mode_t mode;
    logic is_word;
    logic short2;
    logic [11:0] field;
    logic [15:0] const16;
  } oag_req_t;
  typedef struct packed {
    logic [17:0] addr;
    logic [3:0] bitpos;
    logic is_word;
  } oag_res_t;
endpackage : oag_pkg

// [core/oag_core.sv]
`timescale 1ns/1ps
// Functional notes
// - Register fields are four bits, context relative
// - Short address is base plus scaled field
// - Direct 00h-EFh maps to FE00h plus twice
// - Direct special register: word or low byte
// - Direct F0h-FFh uses low nibble and context
// - Bit offset 00h-7Fh uses base FD00h
// - Bit offset 80h-EFh uses base FF00h
// - Bit offset F0h-FFh selects context word register
// - Bit operand: offset byte plus bit position
// - Long bits 15:14 pick a page pointer
// - Four pointer bits join fourteen offset bits
// - Segmentation off keeps only two pointer bits
// - Odd word access in long modes traps
// - Reset pointers give identity mapping
// - Pointer register at context plus twice index
// - Pre-decrement by one or two first
// - Post-increment by one or two afterwards
// - Constant added, pointer left unchanged
// - Indirect long address translated like direct
`include "oag_cfg.svh"
module oag_core #(
  parameter int DPP_W = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic req_valid,
  input oag_pkg::oag_req_t req,
  input wire logic [15:0] context_pointer,
  input wire logic seg_dis,
  input wire logic ptr_rdata_valid,
  input wire logic [15:0] ptr_rdata,
  input wire logic dpp_we,
  input wire logic [1:0] dpp_sel,
  input wire logic [DPP_W-1:0] dpp_wdata,
  output logic req_ready_ff,
  output logic out_valid_ff,
  output oag_pkg::oag_res_t res_ff,
  output logic trap_ff,
  output logic ptr_rd_req_ff,
  output logic [15:0] ptr_addr_ff,
  output logic ptr_wr_en_ff,
  output logic [15:0] ptr_wr_data_ff
);
  import oag_pkg::*;

  if (DPP_W < `OAG_PAGE_W)
  begin : g_chk
    $error("DPP_W too narrow for page number");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [15:0] gpr_addr(logic [15:0] cp,
                                           logic [3:0] idx,
                                           logic w);
    gpr_addr = w ? cp + {11'h000, idx, 1'b0} : cp + {12'h000, idx};
  endfunction : gpr_addr

  function automatic logic [15:0] short_addr(oag_mode_t m,
                                             logic [7:0] f,
                                             logic [15:0] cp,
                                             logic w);
    logic [15:0] r;
    r = 16'h0000;
    unique case (m)
      OAG_RW: r = gpr_addr(cp, f[3:0], 1'b1);
      OAG_RB: r = gpr_addr(cp, f[3:0], 1'b0);
      OAG_REG:
      begin
        if (f < `OAG_GPR_MIN)
          r = `OAG_SFR_BASE + {7'h00, f, 1'b0};
        else
          r = gpr_addr(cp, f[3:0], w);
      end
      OAG_BITOFF, OAG_BITADDR:
      begin
        // Bit space is always word scaled
        if (f < `OAG_SFRBIT_MIN)
          r = `OAG_RAMBIT_BASE + {8'h00, f[6:0], 1'b0};
        else if (f < `OAG_GPR_MIN)
          r = `OAG_SFRBIT_BASE + {8'h00, f[6:0], 1'b0};
        else
          r = gpr_addr(cp, f[3:0], 1'b1);
      end
      default: r = 16'h0000;
    endcase
    short_addr = r;
  endfunction : short_addr

  function automatic logic [17:0] xlate(logic [15:0] la,
                                        logic [DPP_W-1:0] data_page_pointer,
                                        logic sd);
    logic [3:0] page;
    page = data_page_pointer[3:0];
    if (sd)
      page = {2'b00, data_page_pointer[1:0]};
    xlate = {page, la[`OAG_OFF_MSB:0]};
  endfunction : xlate

  // ****************************************
  // State
  // ****************************************
  oag_state_t state_ff;
  oag_state_t nxt_state;
  oag_req_t req_ff;
  logic [DPP_W-1:0] dpp_ff [4];
  logic accept;
  logic in_ind;
  logic fetch_done;
  logic [15:0] delta;
  logic [15:0] ptr_eff;
  logic [15:0] long_ind;
  logic [17:0] phys_ind;
  logic [17:0] phys_dir;
  logic dir_trap;
  logic ind_trap;
  logic [3:0] ptr_idx;

  assign accept = req_valid && req_ready_ff;
  assign in_ind = req.mode inside {OAG_IND, OAG_POSTINC, OAG_PREDEC,
                                   OAG_PLUSK};
  assign fetch_done = (state_ff == OAG_WAIT) && ptr_rdata_valid;
  // Restricted pointers only reach the first four word registers
  assign ptr_idx = req.short2 ? {2'b00, req.field[1:0]} : req.field[3:0];

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      OAG_IDLE: if (accept && in_ind) nxt_state = OAG_WAIT;
      OAG_WAIT: if (ptr_rdata_valid) nxt_state = OAG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_ff <= OAG_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      req_ready_ff <= 1'b0;
    else
      req_ready_ff <= (nxt_state == OAG_IDLE);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      req_ff <= '0;
    else if (accept)
      req_ff <= req;
  end

  // ****************************************
  // Page pointers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        dpp_ff[i] <= DPP_W'(i);
    end
    else if (dpp_we)
      dpp_ff[dpp_sel] <= dpp_wdata;
  end

  // ****************************************
  // Address paths
  // ****************************************
  always_comb
  begin
    phys_dir = xlate(req.const16, dpp_ff[req.const16[15:`OAG_SEL_LSB]],
                     seg_dis);
    if (req.mode != OAG_MEM)
    begin
      if (req.mode == OAG_BITADDR)
        phys_dir = {2'b00, short_addr(req.mode, req.field[11:4],
                                      context_pointer, req.is_word)};
      else
        phys_dir = {2'b00, short_addr(req.mode, req.field[7:0],
                                      context_pointer, req.is_word)};
    end
  end
  assign dir_trap = (req.mode == OAG_MEM) && req.is_word
                    && req.const16[0];

  assign delta = req_ff.is_word ? `OAG_DELTA_W : `OAG_DELTA_B;
  assign ptr_eff = (req_ff.mode == OAG_PREDEC) ?
                   ptr_rdata - delta : ptr_rdata;
  assign long_ind = (req_ff.mode == OAG_PLUSK) ?
                    ptr_eff + req_ff.const16 : ptr_eff;
  assign phys_ind = xlate(long_ind,
                          dpp_ff[long_ind[15:`OAG_SEL_LSB]],
                          seg_dis);
  assign ind_trap = req_ff.is_word && long_ind[0];

  // ****************************************
  // Result and trap
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      out_valid_ff <= 1'b0;
      trap_ff <= 1'b0;
      res_ff <= '0;
    end
    else
    begin
      out_valid_ff <= 1'b0;
      trap_ff <= 1'b0;
      if (accept && !in_ind)
      begin
        out_valid_ff <= !dir_trap;
        trap_ff <= dir_trap;
        res_ff.addr <= phys_dir;
        // Low byte only: an even word address for special register byte ops
        res_ff.is_word <= req.is_word;
        res_ff.bitpos <= (req.mode == OAG_BITADDR) ?
                         req.field[3:0] : 4'h0;
      end
      else if (fetch_done)
      begin
        out_valid_ff <= !ind_trap;
        trap_ff <= ind_trap;
        res_ff.addr <= phys_ind;
        res_ff.is_word <= req_ff.is_word;
        res_ff.bitpos <= 4'h0;
      end
    end
  end

  // ****************************************
  // Pointer fetch and writeback
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ptr_rd_req_ff <= 1'b0;
      ptr_addr_ff <= 16'h0000;
    end
    else
    begin
      ptr_rd_req_ff <= accept && in_ind;
      if (accept && in_ind)
        ptr_addr_ff <= gpr_addr(context_pointer, ptr_idx, 1'b1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ptr_wr_en_ff <= 1'b0;
      ptr_wr_data_ff <= 16'h0000;
    end
    else
    begin
      // A trapped access leaves the pointer untouched
      ptr_wr_en_ff <= fetch_done && !ind_trap
                      && (req_ff.mode inside {OAG_PREDEC,
                                              OAG_POSTINC});
      if (fetch_done)
        ptr_wr_data_ff <= (req_ff.mode == OAG_POSTINC) ?
                          ptr_rdata + delta : ptr_eff;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence ind_issue_s;
    accept && in_ind ##1 ptr_rd_req_ff;
  endsequence
  sequence fetch_s(oag_mode_t m);
    fetch_done && req_ff.mode == m;
  endsequence

  sfr_reg_addr_a: assert property (
    accept && req.mode == OAG_REG && req.field[7:0] < `OAG_GPR_MIN
    |=> out_valid_ff && res_ff.addr ==
        {2'b00, `OAG_SFR_BASE + {7'h00, $past(req.field[7:0]), 1'b0}})
    else $error("special register address wrong");

  gpr_reg_addr_a: assert property (
    accept && req.mode == OAG_REG && req.field[7:4] == 4'hF
    && req.is_word
    |=> res_ff.addr == {2'b00, $past(context_pointer)
        + {11'h000, $past(req.field[3:0]), 1'b0}})
    else $error("register via direct field wrong");

  ram_bit_a: assert property (
    accept && req.mode == OAG_BITOFF && !req.field[7]
    |=> res_ff.addr[15:8] == 8'hFD && !res_ff.addr[0])
    else $error("bit ram word address wrong");

  sfr_bit_a: assert property (
    accept && req.mode == OAG_BITOFF && req.field[7:4] == 4'h8
    |=> res_ff.addr[15:8] == 8'hFF)
    else $error("bit special register address wrong");

  mem_offset_a: assert property (
    accept && req.mode == OAG_MEM && !dir_trap
    |=> out_valid_ff
        && res_ff.addr[`OAG_OFF_MSB:0] == $past(req.const16[13:0]))
    else $error("page offset not passed through");

  seg_zero_a: assert property (
    accept && req.mode == OAG_MEM && seg_dis
    |=> res_ff.addr[17:16] == 2'b00)
    else $error("segment escaped while disabled");

  odd_word_trap_a: assert property (
    accept && req.mode == OAG_MEM && req.is_word && req.const16[0]
    |=> trap_ff && !out_valid_ff)
    else $error("odd word access not trapped");

  reset_map_a: assert property (
    out_valid_ff && $past(accept) && $past(req.mode) == OAG_MEM
    && !$past(dpp_we)
    && $past(dpp_ff[3]) == DPP_W'(3) && $past(dpp_ff[1]) == DPP_W'(1)
    && $past(dpp_ff[0]) == '0 && $past(dpp_ff[2]) == DPP_W'(2)
    && !$past(seg_dis)
    |-> res_ff.addr == {2'b00, $past(req.const16)})
    else $error("identity mapping broken");

  ptr_fetch_a: assert property (
    ind_issue_s |-> state_ff == OAG_WAIT && !req_ready_ff
    && ptr_addr_ff == $past(context_pointer) + {11'h000,
       ($past(req.short2) ? {2'b00, $past(req.field[1:0])}
                          : $past(req.field[3:0])), 1'b0})
    else $error("pointer fetch sequence wrong");

  predec_wb_a: assert property (
    fetch_s(OAG_PREDEC)
    |=> trap_ff || (ptr_wr_en_ff && ptr_wr_data_ff == $past(ptr_rdata)
        - ($past(req_ff.is_word) ? `OAG_DELTA_W : `OAG_DELTA_B)))
    else $error("pre-decrement writeback wrong");

  postinc_wb_a: assert property (
    fetch_done && req_ff.mode == OAG_POSTINC && !ind_trap
    |=> ptr_wr_en_ff && out_valid_ff ##1 !ptr_wr_en_ff)
    else $error("post-increment writeback missing");

  plusk_keep_a: assert property (
    fetch_s(OAG_PLUSK) |=> !ptr_wr_en_ff)
    else $error("constant mode altered pointer");

  trap_no_wb_a: assert property (
    trap_ff |-> !ptr_wr_en_ff && !out_valid_ff)
    else $error("trapped access updated pointer");
endmodule : oag_core

// [verification/oag_ptr_mem.sv]
`timescale 1ns/1ps
// ****************
// Pointer memory
// ****************
module oag_ptr_mem (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic rd_req,
  input wire logic [3:0] delay,
  input wire logic [15:0] value,
  output logic rdata_valid_ff,
  output logic [15:0] rdata_ff
);
  logic [4:0] cnt_ff;
  // Idle data flips each cycle so stale words never look valid
  always_ff @(posedge ref_clk)
  begin
    rdata_valid_ff <= 1'b0;
    rdata_ff <= ~rdata_ff;
    if (srst)
    begin
      cnt_ff <= 5'h1F;
      rdata_ff <= 16'h0000;
    end
    else if (rd_req)
      cnt_ff <= {1'b0, delay};
    else if (cnt_ff == 5'h00)
    begin
      rdata_valid_ff <= 1'b1;
      rdata_ff <= value;
      cnt_ff <= 5'h1F;
    end
    else if (cnt_ff != 5'h1F)
      cnt_ff <= cnt_ff - 5'h01;
  end
endmodule : oag_ptr_mem

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import oag_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  oag_req_t req = '0;
  logic [15:0] cp = 16'h0000;
  logic seg_dis = 1'b0;
  logic dpp_we = 1'b0;
  logic [1:0] dpp_sel = 2'h0;
  logic [15:0] dpp_wdata = 16'h0000;
  logic [3:0] delay = 4'h0;
  logic [15:0] pval = 16'h0000;
  logic ptr_rdata_valid, req_ready_ff, out_valid_ff, trap_ff;
  logic ptr_rd_req_ff, ptr_wr_en_ff;
  logic [15:0] ptr_rdata, ptr_addr_ff, ptr_wr_data_ff;
  oag_res_t res_ff;
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'hEE92;
  logic [15:0] dpp_m [4];
  oag_core #(.DPP_W(16)) uut (.ref_clk(ref_clk), .srst(srst),
    .req_valid(req_valid), .req(req), .context_pointer(cp),
    .seg_dis(seg_dis), .ptr_rdata_valid(ptr_rdata_valid),
    .ptr_rdata(ptr_rdata), .dpp_we(dpp_we), .dpp_sel(dpp_sel),
    .dpp_wdata(dpp_wdata), .req_ready_ff(req_ready_ff),
    .out_valid_ff(out_valid_ff), .res_ff(res_ff), .trap_ff(trap_ff),
    .ptr_rd_req_ff(ptr_rd_req_ff), .ptr_addr_ff(ptr_addr_ff),
    .ptr_wr_en_ff(ptr_wr_en_ff), .ptr_wr_data_ff(ptr_wr_data_ff));
  oag_ptr_mem mem (.ref_clk(ref_clk), .srst(srst), .rd_req(ptr_rd_req_ff),
    .delay(delay), .value(pval), .rdata_valid_ff(ptr_rdata_valid),
    .rdata_ff(ptr_rdata));
  always #10 ref_clk = ~ref_clk;
  // ****************
  // Helpers
  // ****************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task report_and_stop();
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function logic [17:0] xlat(input logic [15:0] l);
    logic [15:0] pg;
    pg = dpp_m[l[15:14]] & (seg_dis ? 16'h0003 : 16'h000F);
    return {pg[3:0], l[13:0]};
  endfunction : xlat
  task run_one(input int n);
    logic [31:0] r;
    logic [15:0] f, i, bb, a, l, p, d, pa, wd;
    logic [17:0] ea;
    logic [3:0] eb;
    logic et, lg, wr, seen;
    int k;
    r = rnd();
    if (n >= 20 && r[0])
    begin
      dpp_we = 1'b1;
      dpp_sel = r[2:1];
      dpp_wdata = r[31:16];
      dpp_m[r[2:1]] = r[31:16];
      @(posedge ref_clk) #1;
      dpp_we = 1'b0;
    end
    r = rnd();
    req.mode = oag_mode_t'(4'(r[7:0] % 8'd10));
    req.is_word = r[8];
    req.short2 = r[9] & (req.mode >= OAG_IND);
    req.field = r[21:10];
    seg_dis = r[22];
    delay = {2'b00, r[24:23]};
    r = rnd();
    req.const16 = r[15:0];
    pval = r[31:16];
    r = rnd();
    cp = {r[15:1], 1'b0};
    // ****************
    // Reference model
    // ****************
    f = {8'h00, req.field[7:0]};
    i = req.short2 ? {14'h0, req.field[1:0]} : {12'h0, req.field[3:0]};
    bb = (req.mode == OAG_BITADDR) ? {8'h00, req.field[11:4]} : f;
    eb = (req.mode == OAG_BITADDR) ? req.field[3:0] : 4'h0;
    d = req.is_word ? 16'h0002 : 16'h0001;
    pa = cp + (i << 1);
    p = (req.mode == OAG_PREDEC) ? pval - d : pval;
    l = (req.mode == OAG_PLUSK) ? p + req.const16 : p;
    if (req.mode == OAG_MEM)
      l = req.const16;
    case (req.mode)
      OAG_RW: a = pa;
      OAG_RB: a = cp + i;
      OAG_REG: a = (f < 16'h00F0) ? 16'hFE00 + (f << 1) : cp + d * i;
      OAG_BITOFF, OAG_BITADDR:
        a = (bb < 16'h0080) ? 16'hFD00 + (bb << 1) :
          (bb < 16'h00F0) ? 16'hFF00 + ((bb - 16'h0080) << 1) :
          cp + ((bb & 16'h000F) << 1);
      default: a = l;
    endcase
    lg = (req.mode >= OAG_MEM);
    ea = lg ? xlat(l) : {2'b00, a};
    et = lg & req.is_word & l[0];
    wr = ~et & (req.mode == OAG_PREDEC || req.mode == OAG_POSTINC);
    wd = (req.mode == OAG_POSTINC) ? p + d : p;
    seen = 1'b0;
    req_valid = 1'b1;
    chk(req_ready_ff, 1'b1);
    @(posedge ref_clk) #1;
    req_valid = 1'b0;
    for (k = 0; k < 20 && !(out_valid_ff | trap_ff); k++)
    begin
      if (ptr_rd_req_ff)
      begin
        seen = 1'b1;
        chk(ptr_addr_ff, pa);
        chk(req_ready_ff, 1'b0);
      end
      @(posedge ref_clk) #1;
    end
    chk(seen, req.mode >= OAG_IND);
    chk(trap_ff, et);
    chk(out_valid_ff, !et);
    if (!et)
    begin
      chk(res_ff.addr, ea);
      chk(res_ff.addr[15:0], ea[15:0]);
      chk(res_ff.addr[17:16], ea[17:16]);
      chk(res_ff.bitpos, eb);
      chk(res_ff.is_word, req.is_word);
    end
    chk(ptr_wr_en_ff, wr);
    if (wr)
      chk({ptr_addr_ff, ptr_wr_data_ff}, {pa, wd});
    @(posedge ref_clk) #1;
    chk({out_valid_ff, trap_ff, ptr_wr_en_ff}, 3'b000);
  endtask : run_one
  // ****************
  // Main sequence
  // ****************
  task do_reset();
    srst = 1'b1;
    foreach (dpp_m[j])
      dpp_m[j] = 16'(j);
    repeat (4) @(posedge ref_clk);
    #1 srst = 1'b0;
    @(posedge ref_clk) #1;
  endtask : do_reset
  initial
  begin
    do_reset();
    for (int n = 0; n < 400; n++)
      run_one(n);
    // Second reset must restore the identity page mapping
    do_reset();
    for (int n = 0; n < 20; n++)
      run_one(n);
    report_and_stop();
  end
  initial
  begin
    #(20 * 20000);
    fail_count++;
    report_and_stop();
  end
endmodule : testbench
